// ---- rtl/vih_defines.svh ----
// Constants for the vectored interrupt handler: bit positions, vectors, timing.
`ifndef VIH_DEFINES_SVH
`define VIH_DEFINES_SVH
`define VIH_NUM_SOURCES 22
`define VIH_GLOBAL_EN_BIT 7
`define VIH_BASE_SRC_COUNT 6
`define VIH_EXT_SRC_COUNT 8
`define VIH_EXT_A_FIRST 6
`define VIH_EXT_B_FIRST 14
`define VIH_TIMER_CONTROL_REG_EXT0_STYLE_BIT 0
`define VIH_TIMER_CONTROL_REG_EXT0_PEND_BIT 1
`define VIH_TIMER_CONTROL_REG_EXT1_STYLE_BIT 2
`define VIH_TIMER_CONTROL_REG_EXT1_PEND_BIT 3
`define VIH_TIMER_CONTROL_REG_T0_PEND_BIT 5
`define VIH_TIMER_CONTROL_REG_T1_PEND_BIT 7
`define VIH_SRC_EXT0 0
`define VIH_SRC_T0 1
`define VIH_SRC_EXT1 2
`define VIH_SRC_T1 3
`define VIH_SRC_CAN 19
`define VIH_RESET_VECTOR 16'h0000
`define VIH_VECTOR_BASE 16'h0003
`define VIH_VECTOR_STRIDE 16'h0008
`define VIH_REG_RESET 8'h00
`define VIH_DETECT_CYCLES 1
`define VIH_CALL_CYCLES 4
`endif

// ---- rtl/vih_handler.sv ----
// Vectored interrupt handler: pending flags, enables, arbitration, vectoring.
//
// Overview of operation
// - Twenty-two sources, two priority levels, one vector per source.
// - Trigger sets pending flag regardless of enables.
// - Disabled pending flag makes no request.
// - Enabled pending raises request; CPU long-calls vector.
// - Return instruction resumes interrupted program flow.
// - Per-source enable bit gates its request.
// - Global enable bit 7 blocks all when clear.
// - Hardware clears edge external, timer, CAN flags.
// - Still-pending flag re-requests after one instruction.
// - Software-set pending flag acts like hardware.
// - External pins active low, level or edge.
// - External pending flags are control bits 1, 3.
// - Edge mode external flag cleared on vectoring.
// - Level mode external flag mirrors pin.
// - Source n vectors 0x0003 plus 8n, order n.
// - Enable and priority bits mapped by source order.
// - High preempts low; nothing preempts high.
// - Higher level first; ties by source order.
// - Sampled every clock; five-cycle minimum response.
// - Equal or lower waits for return plus one.
`include "vih_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module vih_handler #(
	parameter int NUM_SOURCES = `VIH_NUM_SOURCES
) (
	input wire logic clk,
	input wire logic reset,
	input wire vih_pkg::vih_cfg_t cfg,
	input wire logic ext0_trigger_style,
	input wire logic ext1_trigger_style,
	input wire logic ext_request_pin_0_n,
	input wire logic ext_request_pin_1_n,
	input wire logic [NUM_SOURCES-1:0] periph_event,
	input wire logic [NUM_SOURCES-1:0] sw_set_pending,
	input wire logic [NUM_SOURCES-1:0] sw_clear_pending,
	input wire logic instr_done,
	input wire logic vector_ack,
	input wire logic return_from_irq_instr,
	output vih_pkg::vih_req_t irq_req,
	output logic [15:0] long_call_target,
	output logic [NUM_SOURCES-1:0] pending_flags,
	output logic [1:0] levels_in_service
);
	import vih_pkg::*;

	localparam int RESPONSE_MIN = `VIH_DETECT_CYCLES + `VIH_CALL_CYCLES;

	localparam int MAPPED_SOURCES = `VIH_BASE_SRC_COUNT
		+ 2 * `VIH_EXT_SRC_COUNT;
	localparam bit COUNT_OK = (NUM_SOURCES == `VIH_NUM_SOURCES)
		&& (NUM_SOURCES == MAPPED_SOURCES);
	// The source maps are wired for the full source set, so any other count
	// is refused before it can misroute an enable bit.
	if (!COUNT_OK) begin : g_bad_count
		$error("vih_handler serves exactly 22 sources");
	end
	// One register stage detects a request; the core spends the call cycles.
	if (`VIH_DETECT_CYCLES != 1 || RESPONSE_MIN <= 1) begin : g_bad_timing
		$error("vih_handler needs a one cycle detect stage");
	end

	logic [1:0] pin0_sync_q;
	logic [1:0] pin1_sync_q;
	logic ext0_prev_q;
	logic ext1_prev_q;
	logic [NUM_SOURCES-1:0] pend_q;
	logic [NUM_SOURCES-1:0] enable_bits;
	logic [NUM_SOURCES-1:0] prio_bits;
	logic [NUM_SOURCES-1:0] hw_clear_ok;
	logic [NUM_SOURCES-1:0] eligible;
	logic [NUM_SOURCES-1:0] set_ev;
	logic [NUM_SOURCES-1:0] clr_ev;
	logic ext0_active;
	logic ext1_active;
	logic global_en;
	logic [1:0] in_service_q;
	vih_state_t state_q;
	vih_req_t req_q;
	vih_req_t winner;
	logic vectoring;
	vih_state_t state_d;
	vih_req_t req_d;
	logic [15:0] call_target_q;
	logic [NUM_SOURCES-1:0] elig_high;
	logic [NUM_SOURCES-1:0] elig_low;
	logic any_high;
	logic any_low;
	logic [4:0] high_src;
	logic [4:0] low_src;

	// Pins come from outside the clock domain; the first stage feeds only the
	// second stage.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			pin0_sync_q <= 2'b11;
			pin1_sync_q <= 2'b11;
		end else begin
			pin0_sync_q <= {pin0_sync_q[0], ext_request_pin_0_n};
			pin1_sync_q <= {pin1_sync_q[0], ext_request_pin_1_n};
		end
	end

	assign ext0_active = ~pin0_sync_q[1];
	assign ext1_active = ~pin1_sync_q[1];

	// The previous level resets to inactive, matching the idle pin, so no
	// false edge follows reset.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ext0_prev_q <= 1'b0;
			ext1_prev_q <= 1'b0;
		end else begin
			ext0_prev_q <= ext0_active;
			ext1_prev_q <= ext1_active;
		end
	end

	// Enable and priority bits in source order: six base bits, then the two
	// extended registers of eight bits each.
	genvar m;
	generate
		for (m = 0; m < NUM_SOURCES; m++) begin : g_map
			if (m < `VIH_EXT_A_FIRST) begin : g_base
				assign enable_bits[m] = cfg.base_irq_enable_reg[m];
				assign prio_bits[m] = cfg.base_priority_reg[m];
			end else if (m < `VIH_EXT_B_FIRST) begin : g_ext_a
				localparam int K = m - `VIH_EXT_A_FIRST;
				assign enable_bits[m] = cfg.extended_enable_reg_a[K];
				assign prio_bits[m] = cfg.extended_priority_reg_a[K];
			end else begin : g_ext_b
				localparam int K = m - `VIH_EXT_B_FIRST;
				assign enable_bits[m] = cfg.extended_enable_reg_b[K];
				assign prio_bits[m] = cfg.extended_priority_reg_b[K];
			end
		end
	endgenerate
	assign global_en = cfg.base_irq_enable_reg[`VIH_GLOBAL_EN_BIT];

	// Only these flags are cleared by hardware when the CPU vectors.
	// Level mode external flags follow their pin instead, so a vectoring
	// clear would only race the pin.
	always_comb begin
		hw_clear_ok = '0;
		hw_clear_ok[`VIH_SRC_EXT0] = ext0_trigger_style;
		hw_clear_ok[`VIH_SRC_EXT1] = ext1_trigger_style;
		hw_clear_ok[`VIH_SRC_T0] = 1'b1;
		hw_clear_ok[`VIH_SRC_T1] = 1'b1;
		hw_clear_ok[`VIH_SRC_CAN] = 1'b1;
	end

	// The core takes the held request only while it is presented.
	assign vectoring = (state_q == VIH_REQ) && vector_ack;

	// Edge mode external flags set on a falling pin edge; peripheral events
	// on those two indices are ignored.
	always_comb begin
		set_ev = periph_event | sw_set_pending;
		set_ev[`VIH_SRC_EXT0] = sw_set_pending[`VIH_SRC_EXT0]
			| (ext0_trigger_style & ext0_active & ~ext0_prev_q);
		set_ev[`VIH_SRC_EXT1] = sw_set_pending[`VIH_SRC_EXT1]
			| (ext1_trigger_style & ext1_active & ~ext1_prev_q);
		clr_ev = sw_clear_pending;
		if (vectoring) begin
			clr_ev[req_q.source] = clr_ev[req_q.source]
				| hw_clear_ok[req_q.source];
		end
	end

	// A set arriving with a clear wins, so no event is lost.
	genvar g;
	generate
		for (g = 0; g < NUM_SOURCES; g++) begin : g_pend
			if (g == `VIH_SRC_EXT0 || g == `VIH_SRC_EXT1) begin : g_ext
				logic style;
				logic level;
				assign style = (g == `VIH_SRC_EXT0) ? ext0_trigger_style
					: ext1_trigger_style;
				assign level = (g == `VIH_SRC_EXT0) ? ext0_active
					: ext1_active;
				// In level mode the flag follows the pin, so software clears
				// are ignored there; a software set still raises it.
				always_ff @(posedge clk or posedge reset) begin
					if (reset) begin
						pend_q[g] <= 1'b0;
					end else if (!style) begin
						pend_q[g] <= level | sw_set_pending[g];
					end else if (set_ev[g]) begin
						pend_q[g] <= 1'b1;
					end else if (clr_ev[g]) begin
						pend_q[g] <= 1'b0;
					end
				end
			end else begin : g_std
				always_ff @(posedge clk or posedge reset) begin
					if (reset) begin
						pend_q[g] <= 1'b0;
					end else if (set_ev[g]) begin
						pend_q[g] <= 1'b1;
					end else if (clr_ev[g]) begin
						pend_q[g] <= 1'b0;
					end
				end
			end
		end
	endgenerate

	assign pending_flags = pend_q;
	// Disabled flags stay set but are invisible to arbitration.
	assign eligible = pend_q & enable_bits & {NUM_SOURCES{global_en}};

	// Split the eligible set by level; a priority bit of one means high.
	assign elig_high = eligible & prio_bits;
	assign elig_low = eligible & ~prio_bits;
	assign any_high = |elig_high;
	assign any_low = |elig_low;

	// Lowest index wins within a level: the downward scan lets the lowest
	// eligible index overwrite every higher one.
	always_comb begin
		high_src = 5'h00;
		low_src = 5'h00;
		for (int i = NUM_SOURCES - 1; i >= 0; i--) begin
			if (elig_high[i]) begin
				high_src = i[4:0];
			end
			if (elig_low[i]) begin
				low_src = i[4:0];
			end
		end
	end

	// Fixed order arbitration: any high request beats every low one.
	always_comb begin
		winner = '0;
		winner.valid = any_high | any_low;
		winner.high = any_high;
		winner.source = any_high ? high_src : low_src;
		winner.vector = `VIH_VECTOR_BASE
			+ `VIH_VECTOR_STRIDE * {11'h000, winner.source};
		// Preemption only by a strictly higher level than those in service.
		// A high routine blocks everything, a low one all but high requests.
		if (in_service_q[1] || (in_service_q[0] && !any_high)) begin
			winner.valid = 1'b0;
		end
	end

	// Request sequencing; after a return one instruction must finish first.
	// A return wins over a new request, so no request is left standing while
	// the hold state ignores the acknowledge.
	always_comb begin
		state_d = state_q;
		req_d = req_q;
		unique case (state_q)
			VIH_IDLE: begin
				if (return_from_irq_instr) begin
					state_d = VIH_RETURN_FROM_IRQ_INSTR_HOLD;
				end else if (winner.valid) begin
					state_d = VIH_REQ;
					req_d = winner;
				end
			end
			VIH_REQ: begin
				if (vector_ack) begin
					state_d = VIH_IDLE;
					req_d = '0;
				end else if (return_from_irq_instr) begin
					state_d = VIH_RETURN_FROM_IRQ_INSTR_HOLD;
					req_d = '0;
				end else if (winner.valid) begin
					req_d = winner;
				end else begin
					state_d = VIH_IDLE;
					req_d = '0;
				end
			end
			VIH_RETURN_FROM_IRQ_INSTR_HOLD: begin
				if (instr_done) begin
					state_d = VIH_IDLE;
				end
			end
			default: begin
				state_d = VIH_IDLE;
				req_d = '0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_q <= VIH_IDLE;
			req_q <= '0;
		end else begin
			state_q <= state_d;
			req_q <= req_d;
		end
	end

	// The call target is registered from the same next value, so it never
	// lags the request that it belongs to.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			call_target_q <= `VIH_RESET_VECTOR;
		end else begin
			if (req_d.valid) begin
				call_target_q <= req_d.vector;
			end else begin
				call_target_q <= `VIH_RESET_VECTOR;
			end
		end
	end

	// In-service levels: set on vectoring, innermost cleared on return.
	// Both levels set means a high routine nests in a low one, so the return
	// belongs to the high one.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			in_service_q <= 2'b00;
		end else if (vectoring) begin
			if (req_q.high) begin
				in_service_q[1] <= 1'b1;
			end else begin
				in_service_q[0] <= 1'b1;
			end
		end else if (return_from_irq_instr) begin
			if (in_service_q[1]) begin
				in_service_q[1] <= 1'b0;
			end else begin
				in_service_q[0] <= 1'b0;
			end
		end
	end

	assign irq_req = req_q;
	assign long_call_target = call_target_q;
	assign levels_in_service = in_service_q;

endmodule // vih_handler
`default_nettype wire

// ---- rtl/vih_pkg.sv ----
// Types shared by the vectored interrupt handler.
package vih_pkg;
	typedef struct packed {
		logic [7:0] base_irq_enable_reg;
		logic [7:0] extended_enable_reg_a;
		logic [7:0] extended_enable_reg_b;
		logic [7:0] base_priority_reg;
		logic [7:0] extended_priority_reg_a;
		logic [7:0] extended_priority_reg_b;
	} vih_cfg_t;
	typedef struct packed {
		logic valid;
		logic high;
		logic [4:0] source;
		logic [15:0] vector;
	} vih_req_t;
	typedef enum logic [1:0] {
		VIH_IDLE = 2'b00,
		VIH_REQ = 2'b01,
		VIH_RETURN_FROM_IRQ_INSTR_HOLD = 2'b10
	} vih_state_t;
endpackage

// ---- tb/vih_cpu_model.sv ----
// Core-side model that takes vectoring requests and retires instructions.
`timescale 1ns/1ps
`default_nettype none
module vih_cpu_model (
	input wire logic clk,
	input wire logic reset,
	input wire vih_pkg::vih_req_t irq_req,
	input wire logic [3:0] ack_delay,
	output logic vector_ack,
	output logic instr_done
);
	import vih_pkg::*;
	logic [3:0] wait_q;
	// Instructions take two cycles; ack_delay makes a slow core.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			wait_q <= 4'h0;
			vector_ack <= 1'b0;
			instr_done <= 1'b0;
		end else begin
			instr_done <= !instr_done;
			vector_ack <= irq_req.valid && !vector_ack &&
				wait_q >= ack_delay;
			wait_q <= (irq_req.valid && !vector_ack) ? wait_q + 4'h1 : 4'h0;
		end
	end
endmodule // vih_cpu_model
`default_nettype wire

// ---- tb/vih_handler_properties.sv ----
// Checker of the interrupt handler request and service outputs.
`timescale 1ns/1ps
`default_nettype none
module vih_handler_properties #(
	parameter int NUM_SOURCES = 22
) (
	input wire logic clk,
	input wire logic reset,
	input wire vih_pkg::vih_cfg_t cfg,
	input wire logic [NUM_SOURCES-1:0] sw_set_pending,
	input wire logic [NUM_SOURCES-1:0] sw_clear_pending,
	input wire logic instr_done,
	input wire logic vector_ack,
	input wire vih_pkg::vih_req_t irq_req,
	input wire logic [15:0] long_call_target,
	input wire logic [NUM_SOURCES-1:0] pending_flags,
	input wire logic [1:0] levels_in_service
);
	import vih_pkg::*;
	logic [21:0] en_vec;
	logic [21:0] elig_q;
	assign en_vec = {cfg.extended_enable_reg_b, cfg.extended_enable_reg_a,
		cfg.base_irq_enable_reg[5:0]} & {22{cfg.base_irq_enable_reg[7]}};
	// The request is registered, so it answers to eligibility one edge back.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			elig_q <= '0;
		end else begin
			elig_q <= pending_flags & en_vec;
		end
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	vector_map_a: assert property (
		irq_req.valid |-> irq_req.vector == 16'h0003 + {8'h00, irq_req.source, 3'h0})
		else $error("Bad vector.");
	call_target_a: assert property (
		long_call_target == (irq_req.valid ? irq_req.vector : 16'h0000))
		else $error("Bad call target.");
	eligible_only_a: assert property (
		irq_req.valid |-> elig_q[irq_req.source])
		else $error("Request from an ineligible source.");
	prompt_request_a: assert property (
		(pending_flags & en_vec) != '0 && levels_in_service == 2'b00 && instr_done
		&& !vector_ack && sw_clear_pending == '0 |=> ##[0:1] irq_req.valid)
		else $error("Eligible flag gave no request.");
	level_entry_a: assert property (
		irq_req.valid && vector_ack |=> levels_in_service[$past(irq_req.high)])
		else $error("Level not marked in service.");
	high_blocks_all_a: assert property (
		levels_in_service[1] |-> !irq_req.valid)
		else $error("Request during a high routine.");
	hw_clear_a: assert property (
		irq_req.valid && vector_ack && irq_req.source inside {5'h01, 5'h03, 5'h13}
		|=> !pending_flags[$past(irq_req.source)])
		else $error("Flag not cleared on vectoring.");
	sw_set_a: assert property (
		sw_set_pending != '0 |=>
		(pending_flags & $past(sw_set_pending)) == $past(sw_set_pending))
		else $error("Software set did not land.");
endmodule // vih_handler_properties
bind vih_handler vih_handler_properties #(.NUM_SOURCES(NUM_SOURCES)) u_props (
	.clk, .reset, .cfg, .sw_set_pending, .sw_clear_pending, .instr_done,
	.vector_ack, .irq_req, .long_call_target, .pending_flags,
	.levels_in_service);
`default_nettype wire

// ---- tb/vih_handler_tb.sv ----
// Self-checking bench for the vectored interrupt handler.
`timescale 1ns/1ps
`default_nettype none
module vih_handler_tb;
	import vih_pkg::*;
	logic clk, reset, instr_done, vector_ack, return_from_irq_instr;
	logic ext0_trigger_style, ext1_trigger_style;
	logic ext_request_pin_0_n, ext_request_pin_1_n;
	logic [21:0] periph_event, sw_set_pending, sw_clear_pending, pending_flags;
	logic [15:0] long_call_target;
	logic [1:0] levels_in_service;
	logic [3:0] ack_delay;
	vih_cfg_t cfg;
	vih_req_t irq_req;
	int n_fail;
	int samples_checked;
	vih_handler u_vih_handler (.*);
	vih_cpu_model u_vih_cpu_model (.*);
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %0t: saw %0h, expected %0h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic pulse(input logic [21:0] set_m, input logic [21:0] clr_m);
		sw_set_pending = set_m;
		sw_clear_pending = clr_m;
		cyc(1);
		sw_set_pending = '0;
		sw_clear_pending = '0;
	endtask
	// Waits for a request, checks it, then waits until the core takes it.
	task automatic serve(input int s, input int hi);
		int k;
		k = 0;
		while (irq_req.valid !== 1'b1 && k < 40) begin
			cyc(1);
			k++;
		end
		check(irq_req.source, s);
		check(irq_req.vector, 16'h0003 + 8 * s);
		check(irq_req.high, hi);
		check(long_call_target, 16'h0003 + 8 * s);
		while (irq_req.valid === 1'b1 && k < 80) begin
			cyc(1);
			k++;
		end
		check(long_call_target, 16'h0000);
		check(levels_in_service[hi], 1'b1);
	endtask
	task automatic ret();
		return_from_irq_instr = 1'b1;
		cyc(1);
		return_from_irq_instr = 1'b0;
		cyc(4);
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	initial begin
		#300000;
		n_fail++;
		tally_and_finish();
	end
	initial begin
		reset = 1'b1;
		cfg = '0;
		{ext0_trigger_style, ext1_trigger_style} = 2'b11;
		{ext_request_pin_0_n, ext_request_pin_1_n} = 2'b11;
		{periph_event, sw_set_pending, sw_clear_pending} = '0;
		return_from_irq_instr = 1'b0;
		ack_delay = 4'h0;
		cyc(10);
		reset = 1'b0;
		cyc(2);
		check(pending_flags, '0);
		check(levels_in_service, 2'b00);
		cfg.base_irq_enable_reg = 8'hBF;
		cfg.extended_enable_reg_a = 8'hFF;
		cfg.extended_enable_reg_b = 8'hFF;
		for (int s = 0; s < 22; s++) begin
			pulse(22'h1 << s, '0);
			serve(s, 0);
			check(pending_flags[s], !(s inside {0, 1, 2, 3, 19}));
			pulse('0, 22'h1 << s);
			ret();
			check(levels_in_service, 2'b00);
		end
		ack_delay = 4'h5;
		cfg.base_irq_enable_reg = 8'h3F;
		periph_event = 22'h20;
		cyc(1);
		periph_event = '0;
		cyc(4);
		check(irq_req.valid, 1'b0);
		check(pending_flags[5], 1'b1);
		cfg.base_irq_enable_reg = 8'h9F;
		cyc(4);
		check(irq_req.valid, 1'b0);
		cfg.base_irq_enable_reg = 8'hBF;
		serve(5, 0);
		ret();
		serve(5, 0);
		pulse('0, 22'h20);
		ret();
		cfg.extended_priority_reg_b = 8'h04;
		pulse(22'h10, '0);
		serve(4, 0);
		pulse(22'h1_0200, '0);
		serve(16, 1);
		check(levels_in_service, 2'b11);
		pulse('0, 22'h1_0000);
		ret();
		check(irq_req.valid, 1'b0);
		pulse('0, 22'h10);
		ret();
		serve(9, 0);
		pulse('0, 22'h200);
		ret();
		ext_request_pin_0_n = 1'b0;
		serve(0, 0);
		check(pending_flags[0], 1'b0);
		ext_request_pin_0_n = 1'b1;
		ret();
		ext1_trigger_style = 1'b0;
		ext_request_pin_1_n = 1'b0;
		serve(2, 0);
		check(pending_flags[2], 1'b1);
		ext_request_pin_1_n = 1'b1;
		cyc(4);
		check(pending_flags[2], 1'b0);
		ret();
		tally_and_finish();
	end
endmodule // vih_handler_tb
`default_nettype wire
